// ---- rtl/albr_defines.svh ----
// constants for the accelerator link transaction bridge
`ifndef ALBR_DEFINES_SVH
`define ALBR_DEFINES_SVH
`define ALBR_FLIT_BITS 512
`define ALBR_BEAT_BITS 256
`define ALBR_ADDR_BITS 64
`define ALBR_CTX_BITS 20
`define ALBR_CMD_SLOTS 2
`define ALBR_FIFO_DEPTH 16
`define ALBR_CACHE_ENTRIES 16
`define ALBR_CHANNELS 4
`define ALBR_CMD_GAP 2
`define ALBR_OP_READ 4'h1
`define ALBR_OP_WRITE 4'h2
`define ALBR_OP_MEM_RD 4'h3
`define ALBR_OP_MEM_WR 4'h4
`define ALBR_OP_RSP 4'h8
`define ALBR_PAGE_SHIFT 12
`endif

// ---- rtl/albr_pkg.sv ----
// types for the accelerator link transaction bridge
package albr_pkg;
  typedef enum logic [3:0] {
    ALBR_IDLE = 4'h0,
    ALBR_CTX_LOOK = 4'h1,
    ALBR_CTX_FETCH = 4'h2,
    ALBR_CTX_WAIT = 4'h3,
    ALBR_XL_LOOK = 4'h4,
    ALBR_CO_REQ = 4'h5,
    ALBR_CO_WAIT = 4'h6,
    ALBR_ARB = 4'h7,
    ALBR_ISSUE = 4'h8,
    ALBR_DATA = 4'h9,
    ALBR_RESP = 4'ha,
    ALBR_SNP_DATA = 4'hb,
    ALBR_SNP_SEND = 4'hc,
    ALBR_SNP_WAIT = 4'hd,
    ALBR_SNP_RET = 4'he
  } albr_state_type;
endpackage : albr_pkg

// ---- rtl/albr_fifo.sv ----
// parameterised valid/ready fifo in flip-flops
`timescale 1ns/1ps
`include "albr_defines.svh"
module albr_fifo #(
  parameter int WIDTH = 512,
  parameter int DEPTH = 16
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] free_count
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;
  assign in_ready = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_q[rd_q];
  assign free_count = DEPTH[AW:0] - cnt_q;
  always_ff @(posedge mclk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule : albr_fifo

// ---- rtl/albr_cache.sv ----
// tagged lookup cache for contexts and translations
`timescale 1ns/1ps
`include "albr_defines.svh"
module albr_cache #(
  parameter int KEYW = 32,
  parameter int VALW = 64,
  parameter int ENTRIES = 16
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [KEYW-1:0] look_key,
  output logic look_hit,
  output logic [VALW-1:0] look_val,
  input wire logic fill_en,
  input wire logic [KEYW-1:0] fill_key,
  input wire logic [VALW-1:0] fill_val,
  input wire logic flush
);
  localparam int IW = $clog2(ENTRIES);
  logic [ENTRIES-1:0] vld_q;
  logic [KEYW-1:0] key_q [ENTRIES];
  logic [VALW-1:0] val_q [ENTRIES];
  logic [IW-1:0] vict_q;
  logic [ENTRIES-1:0] match;
  genvar g;
  generate
    for (g = 0; g < ENTRIES; g++) begin : g_ent
      assign match[g] = vld_q[g] && (key_q[g] == look_key);
    end
  endgenerate
  always_comb begin
    look_val = '0;
    for (int i = 0; i < ENTRIES; i++) begin
      if (match[i]) begin
        look_val = val_q[i];
      end
    end
  end
  assign look_hit = |match;
  // round-robin victim: cheap, and fills are rare next to lookups
  always_ff @(posedge mclk) begin
    if (rst) begin
      vld_q <= '0;
      vict_q <= '0;
    end else if (flush) begin
      vld_q <= '0;
    end else if (fill_en) begin
      vld_q[vict_q] <= 1'b1;
      vict_q <= vict_q + 1'b1;
    end
  end
  always_ff @(posedge mclk) begin
    if (fill_en) begin
      key_q[vict_q] <= fill_key;
      val_q[vict_q] <= fill_val;
    end
  end
endmodule : albr_cache

// ---- rtl/albr_bridge.sv ----
// link transaction bridge: inbound and outbound command paths
`timescale 1ns/1ps
`include "albr_defines.svh"
module albr_bridge
  import albr_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic rx_valid,
  output logic rx_ready,
  input wire logic [`ALBR_FLIT_BITS-1:0] rx_flit,
  input wire logic rx_crc_ok,
  output logic [4:0] rx_credits,
  output logic rx_bad,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [`ALBR_FLIT_BITS-1:0] tx_flit,
  input wire logic pair_ready,
  output logic pair_grant,
  output logic fab_cmd_valid,
  output logic [3:0] fab_cmd_op,
  output logic [`ALBR_ADDR_BITS-1:0] fab_cmd_addr,
  input wire logic fab_cmd_ack,
  output logic fab_din_valid,
  output logic [`ALBR_BEAT_BITS-1:0] fab_din_data,
  output logic fab_din_checkout,
  input wire logic fab_dout_valid,
  input wire logic [`ALBR_BEAT_BITS-1:0] fab_dout_data,
  input wire logic fab_dout_checkout,
  input wire logic snp_valid,
  input wire logic snp_write,
  input wire logic [`ALBR_ADDR_BITS-1:0] snp_addr,
  input wire logic [`ALBR_ADDR_BITS-1:0] accel_base,
  input wire logic [`ALBR_ADDR_BITS-1:0] accel_limit,
  input wire logic [`ALBR_ADDR_BITS-1:0] ctx_table_base,
  input wire logic xl_flush,
  output logic sm_busy
);
  // link command word: [3:0] op, [23:4] context, [87:24] effective address; second slot at +256
  localparam int SLOTW = `ALBR_FLIT_BITS / `ALBR_CMD_SLOTS;
  localparam int CW = 4 + `ALBR_CTX_BITS + `ALBR_ADDR_BITS;
  albr_state_type st_q;
  logic [`ALBR_FLIT_BITS-1:0] flit_q;
  logic slot_q;
  logic [CW-1:0] cmd_q;
  logic [`ALBR_ADDR_BITS-1:0] ra_q;
  logic [`ALBR_ADDR_BITS-1:0] ctx_val_q;
  logic [1:0] beat_q;
  logic [`ALBR_BEAT_BITS-1:0] obuf_q [2];
  logic [`ALBR_BEAT_BITS-1:0] ibuf_q [2];
  logic [`ALBR_CHANNELS-1:0] chan_q;
  logic [1:0] gap_q;
  logic snp_wr_q;
  logic [`ALBR_ADDR_BITS-1:0] snp_addr_q;
  logic arb_rr_q;
  logic [3:0] op;
  logic [`ALBR_CTX_BITS-1:0] ctx;
  logic [`ALBR_ADDR_BITS-1:0] ea;
  logic flit_ok;
  logic is_rsp;
  logic cmd_in_valid;
  logic cmd_out_valid;
  logic cmd_pop;
  logic [`ALBR_FLIT_BITS-1:0] cmd_out;
  logic [4:0] cmd_free;
  logic ctx_hit;
  logic [`ALBR_ADDR_BITS-1:0] ctx_val;
  logic xl_hit;
  logic [`ALBR_ADDR_BITS-1:0] xl_val;
  logic ctx_fill;
  logic xl_fill;
  logic snp_hit;
  logic chan_free;
  logic fab_go;
  logic link_win;
  logic tx_go;
  logic split_next;

  // syntax: a flit must carry a known op in slot 0
  function automatic logic op_legal(input logic [3:0] o);
    op_legal = (o == `ALBR_OP_READ) || (o == `ALBR_OP_WRITE) || (o == `ALBR_OP_RSP);
  endfunction : op_legal

  assign is_rsp = rx_flit[3:0] == `ALBR_OP_RSP;
  assign flit_ok = rx_crc_ok && op_legal(rx_flit[3:0]);
  assign rx_bad = rx_valid && !flit_ok;
  assign cmd_in_valid = rx_valid && flit_ok && !is_rsp;
  assign rx_ready = is_rsp ? 1'b1 : cmd_in_ready_w();
  function automatic logic cmd_in_ready_w();
    cmd_in_ready_w = cmd_free != 5'h0;
  endfunction : cmd_in_ready_w
  assign rx_credits = cmd_free;

  // command and payload flits share one 64-byte entry
  albr_fifo #(.WIDTH(`ALBR_FLIT_BITS), .DEPTH(`ALBR_FIFO_DEPTH)) u_cmd_buf (
    .mclk(mclk),
    .rst(rst),
    .in_valid(cmd_in_valid),
    .in_ready(),
    .in_data(rx_flit),
    .out_valid(cmd_out_valid),
    .out_ready(cmd_pop),
    .out_data(cmd_out),
    .free_count(cmd_free)
  );

  assign op = cmd_q[3:0];
  assign ctx = cmd_q[4 +: `ALBR_CTX_BITS];
  assign ea = cmd_q[4 + `ALBR_CTX_BITS +: `ALBR_ADDR_BITS];
  assign ctx_fill = (st_q == ALBR_CTX_WAIT) && fab_dout_valid && !fab_dout_checkout;
  assign xl_fill = (st_q == ALBR_CO_WAIT) && fab_dout_valid && fab_dout_checkout;

  albr_cache #(.KEYW(`ALBR_CTX_BITS), .VALW(`ALBR_ADDR_BITS), .ENTRIES(`ALBR_CACHE_ENTRIES)) u_ctx (
    .mclk(mclk),
    .rst(rst),
    .look_key(ctx),
    .look_hit(ctx_hit),
    .look_val(ctx_val),
    .fill_en(ctx_fill),
    .fill_key(ctx),
    .fill_val(fab_dout_data[`ALBR_ADDR_BITS-1:0]),
    .flush(xl_flush)
  );

  albr_cache #(.KEYW(`ALBR_ADDR_BITS), .VALW(`ALBR_ADDR_BITS), .ENTRIES(`ALBR_CACHE_ENTRIES)) u_xl (
    .mclk(mclk),
    .rst(rst),
    .look_key(ctx_val_q ^ {ea[`ALBR_ADDR_BITS-1:`ALBR_PAGE_SHIFT], `ALBR_PAGE_SHIFT'h0}),
    .look_hit(xl_hit),
    .look_val(xl_val),
    .fill_en(xl_fill),
    .fill_key(ctx_val_q ^ {ea[`ALBR_ADDR_BITS-1:`ALBR_PAGE_SHIFT], `ALBR_PAGE_SHIFT'h0}),
    .fill_val(fab_dout_data[`ALBR_ADDR_BITS-1:0]),
    .flush(xl_flush)
  );

  assign snp_hit = snp_valid && (snp_addr >= accel_base) && (snp_addr <= accel_limit);
  assign chan_free = ~&chan_q;
  assign fab_go = fab_cmd_valid && fab_cmd_ack;
  // fabric snoop beats local link work; alternate with the paired queue
  assign link_win = !snp_hit && (!pair_ready || !arb_rr_q);
  assign pair_grant = (st_q == ALBR_ARB) && pair_ready && !snp_hit && arb_rr_q;
  assign cmd_pop = (st_q == ALBR_IDLE) && cmd_out_valid && !snp_hit;
  assign sm_busy = st_q != ALBR_IDLE;
  assign tx_go = tx_valid && tx_ready;
  // only a read may share its flit: a write's upper half is its payload
  assign split_next = !slot_q && (op == `ALBR_OP_READ) && (flit_q[SLOTW +: 4] == `ALBR_OP_READ);

  always_comb begin
    fab_cmd_valid = 1'b0;
    fab_cmd_op = 4'h0;
    fab_cmd_addr = '0;
    if (gap_q == 2'h0) begin
      if (st_q == ALBR_CTX_FETCH) begin
        fab_cmd_valid = 1'b1;
        fab_cmd_op = `ALBR_OP_READ;
        fab_cmd_addr = ctx_table_base + {{(`ALBR_ADDR_BITS-`ALBR_CTX_BITS-6){1'b0}}, ctx, 6'h0};
      end else if (st_q == ALBR_ISSUE) begin
        fab_cmd_valid = 1'b1;
        fab_cmd_op = op;
        fab_cmd_addr = ra_q;
      end
    end
  end

  // one machine, stepped through the whole command sequence
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_q <= ALBR_IDLE;
    end else begin
      case (st_q)
        ALBR_IDLE: begin
          if (snp_hit) begin
            st_q <= snp_write ? ALBR_SNP_DATA : ALBR_SNP_SEND;
          end else if (cmd_out_valid) begin
            st_q <= ALBR_CTX_LOOK;
          end
        end
        ALBR_CTX_LOOK: st_q <= ctx_hit ? ALBR_XL_LOOK : ALBR_CTX_FETCH;
        ALBR_CTX_FETCH: if (fab_go) st_q <= ALBR_CTX_WAIT;
        ALBR_CTX_WAIT: if (ctx_fill) st_q <= ALBR_XL_LOOK;
        ALBR_XL_LOOK: st_q <= xl_hit ? ALBR_ARB : ALBR_CO_REQ;
        ALBR_CO_REQ: if (chan_free) st_q <= ALBR_CO_WAIT;
        ALBR_CO_WAIT: if (xl_fill) st_q <= ALBR_ARB;
        ALBR_ARB: if (link_win) st_q <= ALBR_ISSUE;
        ALBR_ISSUE: if (fab_go) st_q <= ALBR_DATA;
        ALBR_DATA: begin
          if (op == `ALBR_OP_WRITE) begin
            if (beat_q == 2'h1) st_q <= ALBR_RESP;
          end else if (fab_dout_valid && !fab_dout_checkout && beat_q == 2'h1) begin
            st_q <= ALBR_RESP;
          end
        end
        ALBR_RESP: if (tx_go) st_q <= split_next ? ALBR_CTX_LOOK : ALBR_IDLE;
        ALBR_SNP_DATA: if (fab_dout_valid && !fab_dout_checkout && beat_q == 2'h1) st_q <= ALBR_SNP_SEND;
        ALBR_SNP_SEND: if (tx_go) st_q <= ALBR_SNP_WAIT;
        ALBR_SNP_WAIT: begin
          if (rx_valid && flit_ok && is_rsp) st_q <= snp_wr_q ? ALBR_IDLE : ALBR_SNP_RET;
        end
        ALBR_SNP_RET: if (beat_q == 2'h1) st_q <= ALBR_IDLE;
        default: st_q <= ALBR_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      gap_q <= 2'h0;
    end else if (fab_go) begin
      gap_q <= 2'(`ALBR_CMD_GAP - 1);
    end else if (gap_q != 2'h0) begin
      gap_q <= gap_q - 2'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      arb_rr_q <= 1'b0;
    end else if ((st_q == ALBR_ARB) && !snp_hit && pair_ready) begin
      arb_rr_q <= !arb_rr_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      chan_q <= '0;
    end else begin
      for (int i = 0; i < `ALBR_CHANNELS; i++) begin
        if ((st_q == ALBR_CO_REQ) && chan_free && (i == first_free())) begin
          chan_q[i] <= 1'b1;
        end else if (xl_fill) begin
          chan_q[i] <= 1'b0;
        end
      end
    end
  end

  function automatic int first_free();
    first_free = 0;
    for (int k = `ALBR_CHANNELS - 1; k >= 0; k--) begin
      if (!chan_q[k]) first_free = k;
    end
  endfunction : first_free

  always_ff @(posedge mclk) begin
    if (rst) begin
      cmd_q <= '0;
      flit_q <= '0;
      slot_q <= 1'b0;
      ctx_val_q <= '0;
      ra_q <= '0;
      snp_wr_q <= 1'b0;
      snp_addr_q <= '0;
    end else begin
      if (cmd_pop) begin
        flit_q <= cmd_out;
        cmd_q <= cmd_out[CW-1:0];
        slot_q <= 1'b0;
      end
      if (st_q == ALBR_RESP && tx_go && split_next) begin
        cmd_q <= flit_q[SLOTW +: CW];
        slot_q <= 1'b1;
      end
      if (st_q == ALBR_CTX_LOOK && ctx_hit) ctx_val_q <= ctx_val;
      if (ctx_fill) ctx_val_q <= fab_dout_data[`ALBR_ADDR_BITS-1:0];
      if (st_q == ALBR_XL_LOOK && xl_hit) ra_q <= xl_val | {52'h0, ea[`ALBR_PAGE_SHIFT-1:0]};
      if (xl_fill) ra_q <= fab_dout_data[`ALBR_ADDR_BITS-1:0] | {52'h0, ea[`ALBR_PAGE_SHIFT-1:0]};
      if (st_q == ALBR_IDLE && snp_hit) begin
        snp_wr_q <= snp_write;
        snp_addr_q <= snp_addr;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      beat_q <= 2'h0;
    end else if (st_q == ALBR_DATA && op == `ALBR_OP_WRITE) begin
      beat_q <= (beat_q == 2'h1) ? 2'h0 : beat_q + 2'h1;
    end else if ((st_q == ALBR_DATA || st_q == ALBR_SNP_DATA) && fab_dout_valid && !fab_dout_checkout) begin
      beat_q <= (beat_q == 2'h1) ? 2'h0 : beat_q + 2'h1;
    end else if (st_q == ALBR_SNP_RET) begin
      beat_q <= (beat_q == 2'h1) ? 2'h0 : beat_q + 2'h1;
    end
  end

  // 32-byte beats pair into one 64-byte flit, low half first
  always_ff @(posedge mclk) begin
    if ((st_q == ALBR_DATA || st_q == ALBR_SNP_DATA) && fab_dout_valid && !fab_dout_checkout) begin
      obuf_q[beat_q[0]] <= fab_dout_data;
    end
    if (st_q == ALBR_ISSUE) begin
      ibuf_q[0] <= flit_q[SLOTW-1:0] ^ {{(SLOTW-CW){1'b0}}, cmd_q};
      ibuf_q[1] <= flit_q[`ALBR_FLIT_BITS-1:SLOTW];
    end
    if (st_q == ALBR_SNP_WAIT && rx_valid && flit_ok && is_rsp) begin
      ibuf_q[0] <= rx_flit[SLOTW-1:0];
      ibuf_q[1] <= rx_flit[`ALBR_FLIT_BITS-1:SLOTW];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      fab_din_valid <= 1'b0;
      fab_din_data <= '0;
      fab_din_checkout <= 1'b0;
    end else begin
      fab_din_valid <= 1'b0;
      fab_din_checkout <= 1'b0;
      if (st_q == ALBR_CO_REQ && chan_free) begin
        fab_din_valid <= 1'b1;
        fab_din_checkout <= 1'b1;
        fab_din_data <= {{(`ALBR_BEAT_BITS-CW){1'b0}}, cmd_q};
      end else if (st_q == ALBR_DATA && op == `ALBR_OP_WRITE) begin
        fab_din_valid <= 1'b1;
        fab_din_data <= ibuf_q[beat_q[0]];
      end else if (st_q == ALBR_SNP_RET) begin
        fab_din_valid <= 1'b1;
        fab_din_data <= ibuf_q[beat_q[0]];
      end
    end
  end

  always_comb begin
    tx_valid = (st_q == ALBR_RESP) || (st_q == ALBR_SNP_SEND);
    tx_flit = '0;
    if (st_q == ALBR_RESP) begin
      tx_flit = {obuf_q[1], obuf_q[0]};
      tx_flit[3:0] = `ALBR_OP_RSP;
    end else if (st_q == ALBR_SNP_SEND) begin
      tx_flit = {obuf_q[1], obuf_q[0]};
      tx_flit[3:0] = snp_wr_q ? `ALBR_OP_MEM_WR : `ALBR_OP_MEM_RD;
      tx_flit[4 +: `ALBR_ADDR_BITS] = snp_addr_q;
    end
  end

  a_split_second: assert property (@(posedge mclk) disable iff (rst)
    (st_q == ALBR_RESP && tx_go && split_next) |=> (st_q == ALBR_CTX_LOOK) && slot_q)
    else $error("second command of flit lost");
  a_cmd_spacing: assert property (@(posedge mclk) disable iff (rst)
    fab_go |=> !fab_cmd_valid) else $error("fabric command issued in back-to-back cycles");
  a_issue_translated: assert property (@(posedge mclk) disable iff (rst)
    (fab_cmd_valid && fab_cmd_op == `ALBR_OP_WRITE) |-> $past(st_q) inside {ALBR_ARB, ALBR_ISSUE})
    else $error("write issued before translation");
  a_ctx_miss_fetch: assert property (@(posedge mclk) disable iff (rst)
    (st_q == ALBR_CTX_LOOK && !ctx_hit) |=> st_q == ALBR_CTX_FETCH) else $error("context miss lost");
  a_co_channel: assert property (@(posedge mclk) disable iff (rst)
    fab_din_checkout |-> $past(chan_free)) else $error("checkout sent with no free channel");
  a_bad_not_stored: assert property (@(posedge mclk) disable iff (rst)
    (rx_valid && !rx_crc_ok) |-> !cmd_in_valid) else $error("bad crc flit accepted");
  a_resp_after_data: assert property (@(posedge mclk) disable iff (rst)
    $rose(st_q == ALBR_RESP) |-> $past(st_q) == ALBR_DATA) else $error("response before data done");
  a_credit_match: assert property (@(posedge mclk) disable iff (rst)
    (cmd_in_valid && rx_credits == 5'h0) |-> !rx_ready) else $error("flit taken with no credit");
  a_busy_hold: assert property (@(posedge mclk) disable iff (rst)
    (st_q == ALBR_RESP && !tx_ready) |=> st_q == ALBR_RESP) else $error("machine freed before response");
  a_snoop_take: assert property (@(posedge mclk) disable iff (rst)
    (st_q == ALBR_IDLE && snp_hit && !snp_write) |=> st_q == ALBR_SNP_SEND) else $error("snoop dropped");
endmodule : albr_bridge

// ---- verif/albr_fab_model.sv ----
// fabric side model: acks commands, returns read beats and checkout answers
`timescale 1ns/1ps
`include "albr_defines.svh"
module albr_fab_model #(
  parameter logic [63:0] PAGE = 64'h0000_0000_0abc_d000
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic stall,
  input wire logic fab_cmd_valid,
  input wire logic [3:0] fab_cmd_op,
  input wire logic [`ALBR_ADDR_BITS-1:0] fab_cmd_addr,
  output logic fab_cmd_ack,
  input wire logic fab_din_valid,
  input wire logic fab_din_checkout,
  output logic fab_dout_valid,
  output logic [`ALBR_BEAT_BITS-1:0] fab_dout_data,
  output logic fab_dout_checkout,
  output int min_gap
);
  logic was = 1'h0;
  logic co_pend = 1'h0;
  int pend = 0;
  int cyc = 0;
  int last = -100;
  logic [63:0] a = '0;
  initial begin
    fab_cmd_ack = 1'h0;
    fab_dout_valid = 1'h0;
    fab_dout_checkout = 1'h0;
    fab_dout_data = '0;
    min_gap = 1000;
  end
  always @(posedge mclk) begin
    cyc++;
    was = fab_cmd_ack && fab_cmd_valid;
    if (was) begin
      if (cyc - last < min_gap) min_gap = cyc - last;
      last = cyc;
      if (fab_cmd_op == `ALBR_OP_READ) pend = 2;
      a = fab_cmd_addr;
    end
    if (fab_din_valid && fab_din_checkout) co_pend = 1'h1;
    if (rst) begin
      pend = 0;
      co_pend = 1'h0;
    end
    #1;
    fab_cmd_ack = 1'h0;
    fab_dout_valid = 1'h0;
    fab_dout_checkout = 1'h0;
    // idle data keeps toggling so a stale beat is never mistaken for a fresh one
    fab_dout_data = ~fab_dout_data;
    if (pend > 0) begin
      fab_dout_valid = 1'h1;
      fab_dout_data = {4{a + 64'(2 - pend)}};
      pend--;
    end else if (co_pend) begin
      fab_dout_valid = 1'h1;
      fab_dout_checkout = 1'h1;
      fab_dout_data = {192'h0, PAGE};
      co_pend = 1'h0;
    end
    if (fab_cmd_valid && !stall && !was && !rst) fab_cmd_ack = 1'h1;
  end
endmodule : albr_fab_model

// ---- verif/accel_link_transaction_bridge_tb.sv ----
// self-checking bench for the link transaction bridge
`timescale 1ns/1ps
`include "albr_defines.svh"
module accel_link_transaction_bridge_tb;
  localparam logic [63:0] PG = 64'h0000_0000_0abc_d000;
  localparam logic [63:0] CB = 64'h0000_0000_0010_0000;
  logic mclk = 1'h0;
  logic rst = 1'h1;
  logic rx_valid = 1'h0;
  logic rx_crc_ok = 1'h1;
  logic tx_ready = 1'h1;
  logic snp_valid = 1'h0;
  logic xl_flush = 1'h0;
  logic pair_ready = 1'h0;
  logic stall = 1'h0;
  logic [511:0] rx_flit = '0;
  logic [63:0] snp_addr = '0;
  logic rx_ready, rx_bad, tx_valid, pair_grant, fab_cmd_valid, fab_cmd_ack, fab_din_valid;
  logic fab_din_checkout, fab_dout_valid, fab_dout_checkout, sm_busy;
  logic [4:0] rx_credits;
  logic [511:0] tx_flit;
  logic [3:0] fab_cmd_op;
  logic [63:0] fab_cmd_addr;
  logic [255:0] fab_din_data, fab_dout_data;
  logic [63:0] q[$];
  int min_gap;
  int n_co = 0;
  int n_din = 0;
  int n_pg = 0;
  logic [255:0] din_last = '0;
  int mismatches = 0;
  int n_compared = 0;
  initial begin
    forever #50 mclk = ~mclk;
  end
  albr_bridge u_dut (.mclk(mclk), .rst(rst), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_flit(rx_flit),
    .rx_crc_ok(rx_crc_ok), .rx_credits(rx_credits), .rx_bad(rx_bad), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_flit(tx_flit), .pair_ready(pair_ready), .pair_grant(pair_grant), .fab_cmd_valid(fab_cmd_valid),
    .fab_cmd_op(fab_cmd_op), .fab_cmd_addr(fab_cmd_addr), .fab_cmd_ack(fab_cmd_ack),
    .fab_din_valid(fab_din_valid), .fab_din_data(fab_din_data), .fab_din_checkout(fab_din_checkout),
    .fab_dout_valid(fab_dout_valid), .fab_dout_data(fab_dout_data), .fab_dout_checkout(fab_dout_checkout),
    .snp_valid(snp_valid), .snp_write(1'h0), .snp_addr(snp_addr), .accel_base(64'h0000_0040_0000_0000),
    .accel_limit(64'h0000_0040_ffff_ffff), .ctx_table_base(CB), .xl_flush(xl_flush), .sm_busy(sm_busy));
  albr_fab_model #(.PAGE(PG)) u_fab (.mclk(mclk), .rst(rst), .stall(stall), .fab_cmd_valid(fab_cmd_valid),
    .fab_cmd_op(fab_cmd_op), .fab_cmd_addr(fab_cmd_addr), .fab_cmd_ack(fab_cmd_ack),
    .fab_din_valid(fab_din_valid), .fab_din_checkout(fab_din_checkout), .fab_dout_valid(fab_dout_valid),
    .fab_dout_data(fab_dout_data), .fab_dout_checkout(fab_dout_checkout), .min_gap(min_gap));
  always @(posedge mclk) begin
    if (fab_cmd_valid && fab_cmd_ack) q.push_back(fab_cmd_addr);
    if (fab_din_valid) n_din++;
    if (fab_din_valid && fab_din_checkout) n_co++;
    if (fab_din_valid) din_last = fab_din_data;
    if (pair_grant) n_pg++;
  end
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [511:0] e, input logic [511:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  function automatic logic sig(input int k);
    case (k)
      0: return tx_valid;
      1: return rx_ready;
      default: return !sm_busy;
    endcase
  endfunction : sig
  task automatic wait_on(input int k);
    int i;
    for (i = 0; i < 400 && sig(k) !== 1'h1; i++) @(posedge mclk) #1;
    if (sig(k) !== 1'h1) begin
      mismatches++;
      $display("CHECK FAILED wait %0d expected 1 seen 0", k);
      summarize();
    end
  endtask : wait_on
  function automatic logic [511:0] cmd(input logic [3:0] op, input logic [19:0] cx, input logic [63:0] ea);
    return {424'h0, ea, cx, op};
  endfunction : cmd
  task automatic send(input logic [511:0] f, input logic ok, input logic bad);
    rx_flit = f;
    rx_crc_ok = ok;
    rx_valid = 1'h1;
    #1;
    chk("rx_bad", {511'h0, bad}, {511'h0, rx_bad});
    wait_on(1);
    @(posedge mclk) #1;
    rx_valid = 1'h0;
    rx_crc_ok = 1'h1;
    // an idle edge keeps a following send from re-raising valid in the same step
    @(posedge mclk) #1;
  endtask : send
  task automatic rd(input logic [19:0] cx, input logic [63:0] ea, input logic miss);
    logic [63:0] ra;
    int c0;
    logic [511:0] rsp;
    ra = PG | {52'h0, ea[11:0]};
    // the response op code sits on top of the low data nibble
    rsp = {{4{ra + 64'h1}}, {4{ra}}};
    rsp[3:0] = `ALBR_OP_RSP;
    c0 = n_co;
    q.delete();
    tx_ready = 1'h0;
    send(cmd(`ALBR_OP_READ, cx, ea), 1'h1, 1'h0);
    wait_on(0);
    repeat (3) @(posedge mclk) #1;
    chk("tx held", 512'h1, {511'h0, tx_valid});
    chk("resp data", rsp, tx_flit);
    chk("n fab cmds", miss ? 512'h2 : 512'h1, 512'(q.size()));
    chk("read ra", {448'h0, ra}, {448'h0, q[$]});
    if (miss) chk("ctx addr", {448'h0, CB + 64'(cx) * 64'h40}, {448'h0, q[0]});
    chk("checkouts", 512'(miss), 512'(n_co - c0));
    tx_ready = 1'h1;
    @(posedge mclk) #1;
    wait_on(2);
    $display("test read ctx %0d done", cx);
  endtask : rd
  task automatic t_bad;
    send(cmd(`ALBR_OP_READ, 20'h1, 64'h0), 1'h0, 1'h1);
    send(cmd(4'h5, 20'h1, 64'h0), 1'h1, 1'h1);
    send(cmd(4'h0, 20'h1, 64'h0), 1'h1, 1'h1);
    repeat (4) @(posedge mclk) #1;
    chk("credits", 512'h10, 512'(rx_credits));
    chk("idle", 512'h0, {511'h0, sm_busy});
    $display("test bad flits done");
  endtask : t_bad
  task automatic t_snoop;
    int d0;
    d0 = n_din;
    snp_addr = 64'h0000_0041_0000_0000;
    snp_valid = 1'h1;
    @(posedge mclk) #1;
    snp_valid = 1'h0;
    repeat (10) @(posedge mclk) #1;
    chk("miss fwd", 512'h0, {511'h0, tx_valid});
    snp_addr = 64'h0000_0040_0000_1000;
    snp_valid = 1'h1;
    @(posedge mclk) #1;
    snp_valid = 1'h0;
    wait_on(0);
    chk("fwd op", 512'(`ALBR_OP_MEM_RD), 512'(tx_flit[3:0]));
    chk("fwd addr", {448'h0, 64'h0000_0040_0000_1000}, {448'h0, tx_flit[67:4]});
    @(posedge mclk) #1;
    send(cmd(`ALBR_OP_RSP, 20'h0, 64'h0), 1'h0, 1'h1);
    repeat (5) @(posedge mclk) #1;
    chk("bad rsp used", 512'h0, 512'(n_din - d0));
    send({64'h0123_4567_89ab_cdef, 444'h0, `ALBR_OP_RSP}, 1'h1, 1'h0);
    wait_on(2);
    // the last return beat is counted one edge after the machine goes idle
    @(posedge mclk) #1;
    chk("ret beats", 512'h2, 512'(n_din - d0));
    chk("ret data", {256'h0, 64'h0123_4567_89ab_cdef, 192'h0}, {256'h0, din_last});
    $display("test snoop done");
  endtask : t_snoop
  task automatic t_fill;
    int i;
    // the stalled fabric keeps the machine parked so the buffer can only grow
    stall = 1'h1;
    for (i = 0; i < 17; i++) send(cmd(`ALBR_OP_READ, 20'h5, 64'h20), 1'h1, 1'h0);
    chk("full credits", 512'h0, 512'(rx_credits));
    chk("full ready", 512'h0, {511'h0, rx_ready});
    stall = 1'h0;
    for (i = 0; i < 17; i++) begin
      wait_on(0);
      @(posedge mclk) #1;
    end
    wait_on(2);
    chk("drained", 512'h10, 512'(rx_credits));
    chk("cmd gap", 512'h1, 512'(min_gap >= 2));
    $display("test fill done");
  endtask : t_fill
  task automatic t_split;
    logic [511:0] f;
    f = cmd(`ALBR_OP_READ, 20'h5, 64'h0000_0000_7777_0100);
    f[511:256] = {168'h0, 64'h0000_0000_7777_0200, 20'h5, `ALBR_OP_READ};
    q.delete();
    send(f, 1'h1, 1'h0);
    for (int k = 0; k < 2; k++) begin
      wait_on(0);
      @(posedge mclk) #1;
    end
    wait_on(2);
    chk("split cmds", 512'h2, 512'(q.size()));
    chk("split 2nd ra", {448'h0, PG | 64'h200}, {448'h0, q[$]});
    $display("test split done");
  endtask : t_split
  task automatic t_pair;
    int g0;
    g0 = n_pg;
    pair_ready = 1'h1;
    rd(20'h5, 64'h0000_0000_7777_0300, 1'h0);
    rd(20'h5, 64'h0000_0000_7777_0400, 1'h0);
    pair_ready = 1'h0;
    chk("pair grants", 512'h1, 512'(n_pg - g0));
    $display("test pair done");
  endtask : t_pair
  initial begin
    repeat (10) @(posedge mclk);
    #1;
    rst = 1'h0;
    chk("rst credits", 512'h10, 512'(rx_credits));
    chk("rst valids", 512'h0, {510'h0, tx_valid, fab_cmd_valid});
    t_bad();
    rd(20'h5, 64'h0000_0000_7777_0123, 1'h1);
    rd(20'h5, 64'h0000_0000_7777_0fe8, 1'h0);
    xl_flush = 1'h1;
    @(posedge mclk) #1;
    xl_flush = 1'h0;
    rd(20'h5, 64'h0000_0000_7777_0040, 1'h1);
    t_snoop();
    t_fill();
    t_split();
    t_pair();
    summarize();
  end
endmodule : accel_link_transaction_bridge_tb
